// ---- dv/i2c_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Open-drain bus master that writes one configuration byte or reads one status byte
// ---------------------------------------------------------------------
module i2c_host_model (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  // Bus idles high through the pull-ups
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Quarter bit of 16 clocks keeps the bit near 400 kHz
  task automatic wait_q();
    repeat (16) @(posedge clock_i);
    #2;
  endtask

  // Data moves only while the clock line is low
  task automatic put_bit(input logic b);
    sda_o = b;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    wait_q();
    scl_o = 1'b0;
    wait_q();
  endtask

  // Release the line and sample it mid high phase
  task automatic get_bit(output logic b);
    sda_o = 1'b1;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    b = sda_i;
    wait_q();
    scl_o = 1'b0;
    wait_q();
  endtask

  // A low line during the ninth clock is an acknowledge
  task automatic get_ack(output logic a);
    logic b;
    get_bit(b);
    a = !b;
  endtask

  // Start condition, then the header byte and its acknowledge
  task automatic send_hdr(input logic [7:0] hdr, output logic a);
    sda_o = 1'b0;
    wait_q();
    scl_o = 1'b0;
    wait_q();
    for (int i = 7; i >= 0; i--) put_bit(hdr[i]);
    get_ack(a);
  endtask

  // Stop condition; the bus then idles high
  task automatic stop_bus();
    sda_o = 1'b0;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    sda_o = 1'b1;
    wait_q();
  endtask

  // Start, address with write bit, one data byte, stop
  task automatic write_byte(input logic [6:0] addr, input logic [7:0] data,
                            output logic ack_a, output logic ack_d);
    ack_d = 1'b0;
    send_hdr({addr, 1'b0}, ack_a);
    if (ack_a) begin
      for (int i = 7; i >= 0; i--) put_bit(data[i]);
      get_ack(ack_d);
    end
    stop_bus();
  endtask

  // Start, address with read bit, one byte, NACK, stop
  task automatic read_byte(input logic [6:0] addr, output logic ack_a,
                           output logic [7:0] data);
    data = 8'h00;
    send_hdr({addr, 1'b1}, ack_a);
    if (ack_a) begin
      for (int i = 7; i >= 0; i--) get_bit(data[i]);
      put_bit(1'b1);
    end
    stop_bus();
  endtask
endmodule // i2c_host_model
`default_nettype wire

// ---- dv/test_touch_feedback.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Self-checking bench for the feedback block
// ---------------------------------------------------------------------
module test_touch_feedback;
  import touch_feedback_pkg::*;
  localparam int unsigned TH   = 4;
  localparam int unsigned PH   = 8;
  localparam int unsigned TD   = 40;
  localparam int unsigned PD   = 100;
  localparam int unsigned STEP = PWM_STEP_CYC;

  logic             clock_i   = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic [BTN_N-1:0] btn       = '0;
  logic             hover     = 1'b0;
  logic             touch     = 1'b0;
  logic             en        = 1'b1;
  logic             scl_w;
  logic             host_sda;
  logic             sda_out;
  logic             oe_n;
  logic [BTN_N-1:0] led;
  logic             prox_led;
  logic [2:0]       state;
  logic             mode;
  logic             buzz;
  wire logic        sda_w;
  int unsigned      miscompares = 0;
  int unsigned      n_checks    = 0;

  // Wired-AND of both parties on the data line
  assign sda_w = host_sda & (oe_n | sda_out);
  always #20 clock_i = ~clock_i;

  touch_feedback #(.TOG_HALF_P(TH), .PRX_HALF_P(PH), .TOG_DUR_P(TD),
    .PRX_DUR_P(PD)) dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(en), .btn_touch_i(btn), .prox_hover_i(hover),
    .prox_touch_i(touch), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_out),
    .sda_oe_n_o(oe_n), .led_o(led), .prox_led_o(prox_led),
    .prox_state_o(state), .prox_mode_o(mode), .buzzer_o(buzz));
  i2c_host_model host_u (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl_w),
    .sda_o(host_sda));

  // Drive a fixed delay after the edge so sampling never races
  task automatic cyc(input int unsigned n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // First high phase and total high time of one tone burst
  task automatic tone(input int unsigned half, input int unsigned dur);
    int unsigned run;
    int unsigned hi;
    int unsigned k;
    run = 0;
    k = 0;
    while (buzz !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    while (buzz === 1'b1 && run < 4 * half) begin
      cyc(1);
      run++;
    end
    check(run, half);
    hi = run;
    repeat (2 * dur) begin
      cyc(1);
      hi += buzz;
    end
    check(hi + half >= dur / 2 && hi <= dur / 2 + half, 1);
    check(buzz, 1'b0);
  endtask

  // On-time of two button LEDs and the proximity LED over one frame
  task automatic duty(output int unsigned c0, c1, cp);
    c0 = 0;
    c1 = 0;
    cp = 0;
    repeat (100 * STEP) begin
      cyc(1);
      c0 += led[0];
      c1 += led[1];
      cp += prox_led;
    end
  endtask

  task automatic t_toggle();
    for (int i = 0; i < BTN_N; i++) begin
      btn[i] = 1'b1;
      tone(TH, TD);
      check(led[i], 1'b1);
      btn[i] = 1'b0;
      cyc(4);
    end
    // Long hold must neither toggle twice nor sound again
    btn[0] = 1'b1;
    cyc(3 * TD);
    check(led[0], 1'b0);
    check(buzz, 1'b0);
    btn[0] = 1'b0;
    cyc(4);
    // Toggle mode shows hovering as a steady proximity LED
    hover = 1'b1;
    cyc(6);
    check({state, prox_led}, {PROX_HOVER, 1'b1});
    hover = 1'b0;
    cyc(6);
  endtask

  task automatic t_addr();
    logic       a;
    logic       d;
    logic [7:0] s;
    // Status read: buttons 1 to 3 toggled once, button 0 twice
    host_u.read_byte(I2C_ADDR, a, s);
    check({a, s}, {1'b1, 1'b0, PROX_OFF, 4'hE});
    host_u.write_byte(7'h36, 8'h01, a, d);
    check(a, 1'b0);
    check(mode, 1'b0);
    host_u.write_byte(I2C_ADDR, 8'h01, a, d);
    check({a, d}, 2'b11);
    check(mode, 1'b1);
  endtask

  task automatic t_prox();
    int unsigned c0;
    int unsigned c1;
    int unsigned cp;
    hover = 1'b1;
    cyc(20);
    check(buzz, 1'b0);
    check(state, PROX_HOVER);
    btn[1] = 1'b1;
    tone(PH, PD);
    duty(c0, c1, cp);
    check(c1, 93 * STEP);
    check(c0, 7 * STEP);
    check(cp, 93 * STEP);
    btn[1] = 1'b0;
    hover = 1'b0;
    cyc(4);
    check(state, PROX_OFF);
    duty(c0, c1, cp);
    check(cp, 7 * STEP);
    check(c1, 7 * STEP);
    touch = 1'b1;
    tone(PH, PD);
    check(state, PROX_TOUCH);
    touch = 1'b0;
    cyc(4);
  endtask

  // Cut a hang well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clock_i);
    miscompares++;
    end_of_test();
  end

  initial begin
    cyc(4);
    sys_rst_i = 1'b0;
    cyc(2);
    check({led, buzz, mode, oe_n}, {4'h0, 3'b001});
    check(state, PROX_OFF);
    // Frozen enable must hide a touch completely
    en = 1'b0;
    btn[0] = 1'b1;
    cyc(8);
    check({led, buzz}, 5'h00);
    btn[0] = 1'b0;
    cyc(2);
    en = 1'b1;
    cyc(4);
    check({led, buzz}, 5'h00);
    t_toggle();
    t_addr();
    t_prox();
    // Reset in mid-run returns to toggle mode with data line released
    sys_rst_i = 1'b1;
    cyc(2);
    sys_rst_i = 1'b0;
    cyc(2);
    check({led, buzz, mode, oe_n}, {4'h0, 3'b001});
    end_of_test();
  end
endmodule // test_touch_feedback

bind touch_feedback touch_feedback_sva #(.TOG_HALF_P(TOG_HALF_P),
  .PRX_HALF_P(PRX_HALF_P)) sva_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .clk_en_i(clk_en_i), .btn_touch_i(btn_touch_i),
  .prox_hover_i(prox_hover_i), .prox_touch_i(prox_touch_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .led_o(led_o),
  .prox_led_o(prox_led_o), .prox_state_o(prox_state_o),
  .prox_mode_o(prox_mode_o), .buzzer_o(buzzer_o));
`default_nettype wire

// ---- dv/touch_feedback_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Port checks of the feedback block
// ---------------------------------------------------------------------
module touch_feedback_sva
  import touch_feedback_pkg::*;
#(
  parameter int unsigned TOG_HALF_P = 4,
  parameter int unsigned PRX_HALF_P = 8
) (
  input wire logic             clock_i,
  input wire logic             sys_rst_i,
  input wire logic             clk_en_i,
  input wire logic [BTN_N-1:0] btn_touch_i,
  input wire logic             prox_hover_i,
  input wire logic             prox_touch_i,
  input wire logic             scl_i,
  input wire logic             sda_i,
  input wire logic             sda_o,
  input wire logic             sda_oe_n_o,
  input wire logic [BTN_N-1:0] led_o,
  input wire logic             prox_led_o,
  input wire logic [2:0]       prox_state_o,
  input wire logic             prox_mode_o,
  input wire logic             buzzer_o
);
  default clocking cb @(posedge clock_i); endclocking
  // Frozen clock enable holds all state, so checks pause with it
  default disable iff (sys_rst_i || !clk_en_i);

  int unsigned hi_run_q;
  // Length of the tone's current high phase
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) hi_run_q <= 0;
    else if (clk_en_i) hi_run_q <= buzzer_o ? hi_run_q + 1 : 0;
  end

  state_onehot_a: assert property ($onehot(prox_state_o))
    else $error("proximity state not one-hot");
  state_touch_a: assert property (prox_touch_i [*3] |=>
    prox_state_o == PROX_TOUCH) else $error("touch state missed");
  state_hover_a: assert property ((prox_hover_i && !prox_touch_i) [*3]
    |=> prox_state_o == PROX_HOVER) else $error("hover state missed");
  state_off_a: assert property ((!prox_hover_i && !prox_touch_i) [*3]
    |=> prox_state_o == PROX_OFF) else $error("off state missed");
  tone_half_a: assert property (buzzer_o |-> hi_run_q < PRX_HALF_P)
    else $error("tone high phase too long");
  buzz_start_a: assert property (!prox_mode_o &&
    (btn_touch_i & ~$past(btn_touch_i)) != '0 |-> ##[2:5] buzzer_o)
    else $error("buzzer did not start on touch");
  led_toggle_a: assert property (!prox_mode_o && btn_touch_i[0] &&
    !$past(btn_touch_i[0]) |-> ##4 led_o[0] != $past(led_o[0], 4))
    else $error("led did not toggle");
  held_steady_a: assert property ((!prox_mode_o && btn_touch_i[0]) [*6]
    |-> $stable(led_o[0])) else $error("held touch retriggered");
  prox_led_a: assert property (!prox_mode_o && $stable(prox_state_o) &&
    $stable(prox_mode_o) |-> prox_led_o == (prox_state_o != PROX_OFF))
    else $error("proximity led wrong");
  sda_drive_a: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("data line moved while clock high");
endmodule // touch_feedback_sva
`default_nettype wire

// ---- src/buzzer_tone.sv ----
`timescale 1ns/1ps
`default_nettype none
module buzzer_tone
  import touch_feedback_pkg::*;
#(
  parameter int unsigned HALF_SHORT = TOG_HALF_CYC,
  parameter int unsigned HALF_LONG  = PRX_HALF_CYC,
  parameter int unsigned DUR_SHORT  = TOG_DUR_CYC,
  parameter int unsigned DUR_LONG   = PRX_DUR_CYC
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  input  wire logic start_i,
  input  wire logic long_i,
  output var  logic tone_o,
  output var  logic busy_o
);

  typedef struct packed {
    logic             active;
    logic             long_sel;
    logic             tone;
    logic [CNT_W-1:0] half_cnt;
    logic [CNT_W-1:0] dur_cnt;
  } bz_t;

  bz_t q, d;
  logic [CNT_W-1:0] half_lim;
  logic [CNT_W-1:0] dur_lim;

  // ---------------------------------------------------------------------
  // Divider and duration timer
  // ---------------------------------------------------------------------
  // A new start restarts the tone, so rapid touches extend the feedback
  always_comb begin
    half_lim = q.long_sel ? CNT_W'(HALF_LONG - 1) : CNT_W'(HALF_SHORT - 1);
    dur_lim  = q.long_sel ? CNT_W'(DUR_LONG - 1) : CNT_W'(DUR_SHORT - 1);
    d = q;
    if (start_i) begin
      d.active   = 1'b1;
      d.long_sel = long_i;
      d.tone     = 1'b1;
      d.half_cnt = '0;
      d.dur_cnt  = '0;
    end else if (q.active) begin
      d.dur_cnt = q.dur_cnt + CNT_W'(1);
      if (q.half_cnt == half_lim) begin
        d.half_cnt = '0;
        d.tone     = ~q.tone; // (R12)
      end else begin
        d.half_cnt = q.half_cnt + CNT_W'(1);
      end
      if (q.dur_cnt == dur_lim) begin
        d.active = 1'b0; // (R12)
        d.tone   = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign tone_o = q.tone;
  assign busy_o = q.active;

endmodule // buzzer_tone
`default_nettype wire

// ---- src/touch_feedback.sv ----
`timescale 1ns/1ps
`default_nettype none
module touch_feedback
  import touch_feedback_pkg::*;
#(
  parameter int unsigned TOG_HALF_P = TOG_HALF_CYC,
  parameter int unsigned PRX_HALF_P = PRX_HALF_CYC,
  parameter int unsigned TOG_DUR_P  = TOG_DUR_CYC,
  parameter int unsigned PRX_DUR_P  = PRX_DUR_CYC
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clk_en_i,
  input  wire logic [BTN_N-1:0] btn_touch_i,
  input  wire logic             prox_hover_i,
  input  wire logic             prox_touch_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output var  logic             sda_o,
  output var  logic             sda_oe_n_o,
  output var  logic [BTN_N-1:0] led_o,
  output var  logic             prox_led_o,
  output var  logic [2:0]       prox_state_o,
  output var  logic             prox_mode_o,
  output var  logic             buzzer_o
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [BTN_N-1:0] btn_s1;
    logic [BTN_N-1:0] btn_s2;
    logic [BTN_N-1:0] btn_prev;
    logic             hov_s1;
    logic             hov_s2;
    logic             tch_s1;
    logic             tch_s2;
    logic             scl_s1;
    logic             scl_s2;
    logic             scl_prev;
    logic             sda_s1;
    logic             sda_s2;
    logic             sda_prev;
    prox_t            prox;
    logic [BTN_N-1:0] toggle;
    logic [7:0]       pwm_pre;
    logic [6:0]       pwm_phase;
    logic [BTN_N-1:0] led;
    logic             prox_led;
    i2c_st_t          ist;
    logic [3:0]       bitcnt;
    logic [7:0]       shreg;
    logic [7:0]       txreg;
    logic [7:0]       cfg;
    logic             sda_oe_n;
    logic             buzz_start;
    logic             buzz_long;
  } state_t;

  state_t q, d;
  logic   buzz_busy;
  logic   buzz_tone;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // PWM compare, shared by the button LEDs and the proximity LED
  function automatic logic pwm_on(input logic [6:0] phase,
                                  input logic       bright);
    pwm_on = bright ? (phase < DUTY_TOUCH) : (phase < DUTY_IDLE);
  endfunction

  // Proximity classification from the two sensing levels
  function automatic prox_t prox_class(input logic hov, input logic tch);
    if (tch) begin
      prox_class = PROX_TOUCH;
    end else if (hov) begin
      prox_class = PROX_HOVER;
    end else begin
      prox_class = PROX_OFF;
    end
  endfunction

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  logic             mode_prox;
  logic [BTN_N-1:0] btn_rise;
  logic             prox_enter_touch;
  logic             scl_rise;
  logic             scl_fall;
  logic             i2c_start;
  logic             i2c_stop;
  logic [7:0]       status;
  prox_t            prox_nx;
  logic             led_bright;

  always_comb begin
    d = q;
    led_bright = 1'b0;

    // Two-stage synchronisers; stage one feeds stage two only
    d.btn_s1   = btn_touch_i;
    d.btn_s2   = q.btn_s1;
    d.btn_prev = q.btn_s2;
    d.hov_s1   = prox_hover_i;
    d.hov_s2   = q.hov_s1;
    d.tch_s1   = prox_touch_i;
    d.tch_s2   = q.tch_s1;
    d.scl_s1   = scl_i;
    d.scl_s2   = q.scl_s1;
    d.scl_prev = q.scl_s2;
    d.sda_s1   = sda_i;
    d.sda_s2   = q.sda_s1;
    d.sda_prev = q.sda_s2;

    mode_prox = q.cfg[CFG_MODE_BIT];
    btn_rise  = q.btn_s2 & ~q.btn_prev; // (R13)

    // Proximity state machine
    prox_nx = prox_class(q.hov_s2, q.tch_s2); // (R6)
    prox_enter_touch = 1'b0;
    unique case (q.prox)
      PROX_OFF:   prox_enter_touch = (prox_nx == PROX_TOUCH); // (R7)
      PROX_HOVER: prox_enter_touch = (prox_nx == PROX_TOUCH); // (R7)
      PROX_TOUCH: prox_enter_touch = 1'b0;
    endcase
    d.prox = prox_nx; // (R6)

    // Toggle state flips once per touch edge, only in toggle mode
    if (!mode_prox) begin
      d.toggle = q.toggle ^ btn_rise; // (R1)
    end

    // Buzzer trigger: profile chosen by the mode at trigger time
    d.buzz_long  = mode_prox;
    d.buzz_start = mode_prox ? ((|btn_rise) || prox_enter_touch) // (R5)
                             : (|btn_rise); // (R2)

    // PWM timebase: 10 us steps, 100 steps per frame
    if (q.pwm_pre == 8'(PWM_STEP_CYC - 1)) begin
      d.pwm_pre = 8'h00;
      d.pwm_phase = (q.pwm_phase == PWM_LAST) ? 7'h00
                                              : q.pwm_phase + 7'h01;
    end else begin
      d.pwm_pre = q.pwm_pre + 8'h01;
    end

    // LED drive; toggle mode is full on/off, no dimming
    for (int i = 0; i < BTN_N; i++) begin
      if (mode_prox) begin
        d.led[i] = pwm_on(q.pwm_phase, q.btn_s2[i]); // (R3) (R4) (R9)
      end else begin
        d.led[i] = q.toggle[i]; // (R1)
      end
    end
    led_bright = (q.prox != PROX_OFF);
    if (mode_prox) begin
      d.prox_led = pwm_on(q.pwm_phase, led_bright); // (R10) (R11)
    end else begin
      d.prox_led = led_bright; // (R10)
    end

    // Status byte returned on I2C reads
    status = 8'h00;
    status[STAT_LED_LSB +: BTN_N] = mode_prox ? q.btn_s2 : q.toggle;
    status[STAT_PRX_LSB +: 3]     = q.prox;
    status[STAT_BUZZ_BIT]         = buzz_busy;

    // I2C slave; SDA changes only while SCL is low
    scl_rise  = q.scl_s2 & ~q.scl_prev;
    scl_fall  = ~q.scl_s2 & q.scl_prev;
    i2c_start = q.scl_s2 & q.scl_prev & q.sda_prev & ~q.sda_s2;
    i2c_stop  = q.scl_s2 & q.scl_prev & ~q.sda_prev & q.sda_s2;

    if (i2c_start) begin
      d.ist      = I2C_HDR;
      d.bitcnt   = 4'h0;
      d.sda_oe_n = 1'b1;
    end else if (i2c_stop) begin
      d.ist      = I2C_IDLE;
      d.sda_oe_n = 1'b1;
    end else begin
      unique case (q.ist)
        I2C_IDLE: begin
          d.sda_oe_n = 1'b1;
        end
        I2C_HDR, I2C_WDATA: begin
          if (scl_rise && q.bitcnt != BITS_PER_BYTE) begin
            d.shreg  = {q.shreg[6:0], q.sda_s2};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
            if (q.ist == I2C_WDATA) begin
              d.cfg      = q.shreg;
              d.sda_oe_n = 1'b0;
              d.ist      = I2C_ACK_W;
            end else if (q.shreg[7:1] == I2C_ADDR) begin
              d.sda_oe_n = 1'b0; // (R8)
              d.ist      = I2C_ACK_A;
            end else begin
              d.ist = I2C_IDLE; // (R8)
            end
          end
        end
        I2C_ACK_A: begin
          if (scl_fall) begin
            d.bitcnt = 4'h0;
            if (q.shreg[0]) begin
              d.txreg    = status;
              d.sda_oe_n = status[7];
              d.bitcnt   = 4'h1;
              d.ist      = I2C_RDATA;
            end else begin
              d.sda_oe_n = 1'b1;
              d.ist      = I2C_WDATA;
            end
          end
        end
        I2C_ACK_W: begin
          if (scl_fall) begin
            d.sda_oe_n = 1'b1;
            d.bitcnt   = 4'h0;
            d.ist      = I2C_WDATA;
          end
        end
        I2C_RDATA: begin
          if (scl_fall) begin
            if (q.bitcnt == BITS_PER_BYTE) begin
              d.sda_oe_n = 1'b1;
              d.ist      = I2C_ACK_R;
            end else begin
              d.txreg    = {q.txreg[6:0], 1'b0};
              d.sda_oe_n = q.txreg[6];
              d.bitcnt   = q.bitcnt + 4'h1;
            end
          end
        end
        I2C_ACK_R: begin
          // Master ACK keeps reading the status byte; NACK ends the read
          if (scl_rise) begin
            d.shreg[0] = q.sda_s2;
          end else if (scl_fall) begin
            if (!q.shreg[0]) begin
              d.txreg    = status;
              d.sda_oe_n = status[7];
              d.bitcnt   = 4'h1;
              d.ist      = I2C_RDATA;
            end else begin
              d.ist = I2C_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Reset releases SDA and parks every FSM; sync stages read idle-high bus
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q          <= '0;
      q.prox     <= PROX_OFF;
      q.ist      <= I2C_IDLE;
      q.cfg      <= CFG_RESET;
      q.sda_oe_n <= 1'b1;
      q.scl_s1   <= 1'b1;
      q.scl_s2   <= 1'b1;
      q.scl_prev <= 1'b1;
      q.sda_s1   <= 1'b1;
      q.sda_s2   <= 1'b1;
      q.sda_prev <= 1'b1;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------
  // Buzzer
  // ---------------------------------------------------------------------
  buzzer_tone #(
    .HALF_SHORT (TOG_HALF_P),
    .HALF_LONG  (PRX_HALF_P),
    .DUR_SHORT  (TOG_DUR_P),
    .DUR_LONG   (PRX_DUR_P)
  ) u_buzzer (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .start_i   (q.buzz_start), // (R2) (R5)
    .long_i    (q.buzz_long),
    .tone_o    (buzz_tone),
    .busy_o    (buzz_busy)
  );

  // ---------------------------------------------------------------------
  // Outputs, registered apart from the tied-low sda_o
  // ---------------------------------------------------------------------
  assign sda_o        = 1'b0; // Open drain: only ever pulls low
  assign sda_oe_n_o   = q.sda_oe_n;
  assign led_o        = q.led;
  assign prox_led_o   = q.prox_led;
  assign prox_state_o = q.prox;
  assign prox_mode_o  = q.cfg[CFG_MODE_BIT];
  assign buzzer_o     = buzz_tone;

endmodule // touch_feedback
`default_nettype wire

// ---- src/touch_feedback_pkg.sv ----
// Function
// (R1) Toggle mode: each new button touch inverts that button's LED state.
// (R2) Toggle mode: each button touch starts a 4 kHz buzzer tone for 100 ms.
// (R3) Brightness mode: untouched LEDs run PWM at 7 percent on-time.
// (R4) Brightness mode: a touched button's LED runs PWM at 93 percent on-time.
// (R5) Proximity mode: button or loop touch gives a 1 kHz tone for 1 s.
// (R6) Proximity sensor is classified as off, hovering or touched.
// (R7) Proximity buzzer fires only on entering touched, never on hovering.
// (R8) I2C slave answers at 7-bit address 0x37; host may run 400 kHz.
// (R9) Proximity mode: a touched button's LED is on while the touch lasts.
// (R10) A hovering object lights the dedicated proximity LED.
// (R11) While hovering, the proximity LED is brighter than when off.
// (R12) Tone is a 50 percent square wave from a clock divider, timed out.
// (R13) Toggles and buzzer fire once per touch rising edge, not while held.
package touch_feedback_pkg;

  // ---------------------------------------------------------------------
  // Clock and sizes
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned BTN_N       = 4;
  localparam int unsigned CNT_W       = 25;
  localparam int unsigned I2C_BUS_KHZ = 400;
  localparam logic [6:0]  I2C_ADDR    = 7'h37;

  // ---------------------------------------------------------------------
  // Buzzer profiles
  // ---------------------------------------------------------------------
  localparam int unsigned TOG_TONE_HZ  = 4000;
  localparam int unsigned TOG_BUZZ_MS  = 100;
  localparam int unsigned PRX_TONE_HZ  = 1000;
  localparam int unsigned PRX_BUZZ_MS  = 1000;
  localparam int unsigned TOG_HALF_CYC = CLK_HZ / (2 * TOG_TONE_HZ);
  localparam int unsigned PRX_HALF_CYC = CLK_HZ / (2 * PRX_TONE_HZ);
  localparam int unsigned TOG_DUR_CYC  = (CLK_HZ / 1000) * TOG_BUZZ_MS;
  localparam int unsigned PRX_DUR_CYC  = (CLK_HZ / 1000) * PRX_BUZZ_MS;

  // ---------------------------------------------------------------------
  // PWM: 100 steps of 10 us, 1 kHz frame
  // ---------------------------------------------------------------------
  localparam int unsigned PWM_STEP_US  = 10;
  localparam int unsigned PWM_STEP_CYC = (CLK_HZ / 1_000_000) * PWM_STEP_US;
  localparam logic [6:0]  PWM_LAST     = 7'h63;
  localparam logic [6:0]  DUTY_IDLE    = 7'h07;
  localparam logic [6:0]  DUTY_TOUCH   = 7'h5D;

  // ---------------------------------------------------------------------
  // I2C byte layouts and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned CFG_MODE_BIT  = 0;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam int unsigned STAT_LED_LSB  = 0;
  localparam int unsigned STAT_PRX_LSB  = 4;
  localparam int unsigned STAT_BUZZ_BIT = 7;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

  // ---------------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    PROX_OFF   = 3'b001,
    PROX_HOVER = 3'b010,
    PROX_TOUCH = 3'b100
  } prox_t;

  typedef enum logic [6:0] {
    I2C_IDLE  = 7'b0000001,
    I2C_HDR   = 7'b0000010,
    I2C_ACK_A = 7'b0000100,
    I2C_WDATA = 7'b0001000,
    I2C_ACK_W = 7'b0010000,
    I2C_RDATA = 7'b0100000,
    I2C_ACK_R = 7'b1000000
  } i2c_st_t;

endpackage
